/* include/mdcb_pkg.sv */
// Package for the multi-device channel bonding control block.
// Assumes one 25 MHz system clock, async active-low reset, AXI4-Lite slave.
// Overview of operation
// - With leader select low the device is bonding leader and drives the two status code pins.
// - With leader select high the device is a follower and only reads the status code pins.
// - Leader select counts only in quad bonding with the receive interface on the reference clock.
// - The all-bonded flag is a wired-AND: the device pulls it low or releases it, never drives high.
// - After resolution the flag is released only when all bonded channels have framing.
// - The flag is held low for the whole bonding resolution process.
// - The flag is driven only in quad bonding on the reference clock, otherwise left alone.
// - With bond inhibit low no channel shifts offset until all bonded channels saw the sequence.
// - With bond inhibit high each channel that saw the sequence may align on its own.
// - Bonding happens only if the selected leader channel is a member of the bonded group.
// - Status codes: 00 reserved, 01 insert one K28.5 after next framing, 10 delete next, 11 normal.
// - The leader updates the status code at the receive character rate.
package mdcb_pkg;

	localparam int MDCB_NCH = 4;

	// Bond status codes
	typedef enum logic [1:0] {
		MDCB_ST_RSVD = 2'h0,
		MDCB_ST_INSERT = 2'h1,
		MDCB_ST_DELETE = 2'h2,
		MDCB_ST_NORMAL = 2'h3
	} mdcb_status_t;

	// Register byte offsets
	localparam logic [3:0] MDCB_REG_CTRL = 4'h0;
	localparam logic [3:0] MDCB_REG_STAT = 4'h4;
	localparam logic [3:0] MDCB_REG_EVT = 4'h8;

	// Control field positions
	localparam int MDCB_CTRL_QUAD = 0;
	localparam int MDCB_CTRL_REFERENCE_CLOCK = 1;
	localparam int MDCB_CTRL_LDRCH = 2;
	localparam int MDCB_CTRL_GROUP = 4;
	localparam logic [31:0] MDCB_CTRL_RST = 32'h0000_00f3;

	localparam logic [1:0] MDCB_RESP_OKAY = 2'h0;
	localparam logic [1:0] MDCB_RESP_SLVERR = 2'h2;

	// Per-channel receive status from the receive path
	typedef struct packed {
		logic [MDCB_NCH-1:0] framed;
		logic [MDCB_NCH-1:0] seq_seen;
		logic [MDCB_NCH-1:0] char_stb;
		logic [1:0] ldr_code;
	} mdcb_rx_t;

	// Per-channel elasticity actions
	typedef struct packed {
		logic [MDCB_NCH-1:0] align_en;
		logic [MDCB_NCH-1:0] ins_k285;
		logic [MDCB_NCH-1:0] del_frame;
	} mdcb_eb_t;

endpackage

/* rtl/mdcb_ctrl.sv */
// Channel bonding control: leader/follower status code pins, wired-AND
// all-bonded flag, inhibit gating and AXI4-Lite configuration.
// Assumes receive status inputs are synchronous to sys_clk.
module mdcb_ctrl
	import mdcb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic leader_sel,
	input wire logic bond_inhibit_n,
	input wire logic [1:0] bond_status_code_i,
	output logic [1:0] bond_status_code_o,
	output logic [1:0] bond_status_code_oe,
	input wire logic bond_all_i,
	output logic bond_all_o,
	output logic bond_all_oe,
	input wire mdcb_rx_t rx,
	output mdcb_eb_t eb,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ----------------------------------------
	// Configuration and state
	// ----------------------------------------
	logic [31:0] ctrl_q;
	logic [1:0] code_q;
	logic [1:0] fcode_q;
	logic resolved_q;
	logic [31:0] ins_cnt_q;
	logic [31:0] del_cnt_q;

	logic active;
	logic is_leader;
	logic [MDCB_NCH-1:0] group;
	logic ldr_member;
	logic all_seen;
	logic all_framed;
	logic [1:0] use_code;

	typedef enum logic [1:0] {
		MDCB_RES_IDLE,
		MDCB_RES_BUSY,
		MDCB_RES_DONE
	} mdcb_res_t;
	mdcb_res_t res_q;

	// Mode decode
	assign active = ctrl_q[MDCB_CTRL_QUAD] & ctrl_q[MDCB_CTRL_REFERENCE_CLOCK];
	assign is_leader = active & ~leader_sel;
	assign group = ctrl_q[MDCB_CTRL_GROUP +: MDCB_NCH];
	assign ldr_member = group[ctrl_q[MDCB_CTRL_LDRCH +: 2]];
	assign all_seen = ((rx.seq_seen & group) == group) & ldr_member;
	assign all_framed = ((rx.framed & group) == group);

	// ----------------------------------------
	// Status code pins
	// ----------------------------------------
	// Leader registers code at the character rate
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			code_q <= MDCB_ST_NORMAL;
		end else if (rx.char_stb[ctrl_q[MDCB_CTRL_LDRCH +: 2]]) begin
			code_q <= rx.ldr_code;
		end
	end

	// Open drain: drive only low bits, leader only
	assign bond_status_code_o = 2'h0;
	assign bond_status_code_oe = is_leader ? ~code_q : 2'h0;

	// Follower samples code per character
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fcode_q <= MDCB_ST_NORMAL;
		end else if (|rx.char_stb) begin
			fcode_q <= bond_status_code_i;
		end
	end

	assign use_code = is_leader ? code_q : fcode_q;

	// ----------------------------------------
	// Bonding resolution
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			res_q <= MDCB_RES_IDLE;
		end else begin
			case (res_q)
				MDCB_RES_IDLE: begin
					if (active & ldr_member) begin
						res_q <= MDCB_RES_BUSY;
					end
				end
				MDCB_RES_BUSY: begin
					if (!active) begin
						res_q <= MDCB_RES_IDLE;
					end else if (all_seen) begin
						res_q <= MDCB_RES_DONE;
					end
				end
				default: begin
					if (!active | !ldr_member) begin
						res_q <= MDCB_RES_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			resolved_q <= 1'b0;
		end else begin
			resolved_q <= (res_q == MDCB_RES_DONE);
		end
	end

	// Wired-AND flag: pull low or release only
	assign bond_all_o = 1'b0;
	assign bond_all_oe = active & ~(resolved_q & all_framed);

	// ----------------------------------------
	// Elasticity buffer actions
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < MDCB_NCH; gi++) begin : g_ch
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					eb.align_en[gi] <= 1'b0;
					eb.ins_k285[gi] <= 1'b0;
					eb.del_frame[gi] <= 1'b0;
				end else begin
					// Inhibit low waits for all, high lets each go
					eb.align_en[gi] <= ldr_member & group[gi] & rx.seq_seen[gi]
						& (bond_inhibit_n | all_seen);
					eb.ins_k285[gi] <= active & group[gi] & rx.char_stb[gi]
						& (use_code == MDCB_ST_INSERT);
					eb.del_frame[gi] <= active & group[gi] & rx.char_stb[gi]
						& (use_code == MDCB_ST_DELETE);
				end
			end
		end
	endgenerate

	// Event counters
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ins_cnt_q <= 32'h0;
			del_cnt_q <= 32'h0;
		end else begin
			if (|eb.ins_k285) begin
				ins_cnt_q <= ins_cnt_q + 32'h1;
			end
			if (|eb.del_frame) begin
				del_cnt_q <= del_cnt_q + 32'h1;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite write
	// ----------------------------------------
	logic aw_held_q;
	logic w_held_q;
	logic [3:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;

	assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
	assign do_write = aw_held_q & w_held_q;

	// Capture address and data in either order
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
			end
		end
	end

	// Control register and write response
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= MDCB_CTRL_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= MDCB_RESP_OKAY;
		end else begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				if (awaddr_q[3:2] == MDCB_REG_CTRL[3:2]) begin
					for (int b = 0; b < 4; b++) begin
						if (wstrb_q[b]) begin
							ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
						end
					end
					s_axi_bresp <= MDCB_RESP_OKAY;
				end else begin
					s_axi_bresp <= MDCB_RESP_SLVERR;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read
	// ----------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= MDCB_RESP_OKAY;
		end else begin
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= MDCB_RESP_OKAY;
				if (s_axi_araddr[3:2] == MDCB_REG_CTRL[3:2]) begin
					s_axi_rdata <= ctrl_q;
				end else if (s_axi_araddr[3:2] == MDCB_REG_STAT[3:2]) begin
					s_axi_rdata <= {18'h0, rx.framed, rx.seq_seen, bond_all_i, resolved_q,
						is_leader, active, use_code};
				end else if (s_axi_araddr[3:2] == MDCB_REG_EVT[3:2]) begin
					s_axi_rdata <= {ins_cnt_q[15:0], del_cnt_q[15:0]};
				end else begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= MDCB_RESP_SLVERR;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

/* dv/mdcb_ctrl_props.sv */
// Assertions on the bonding control ports.
// Bound onto mdcb_ctrl; one clock domain.
module mdcb_ctrl_props
	import mdcb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic leader_sel,
	input wire logic bond_inhibit_n,
	input wire logic [1:0] bond_status_code_o,
	input wire logic [1:0] bond_status_code_oe,
	input wire logic bond_all_o,
	input wire logic bond_all_oe,
	input wire mdcb_rx_t rx,
	input wire mdcb_eb_t eb,
	input wire logic s_axi_bvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Port checks
	// ----
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	// Leader channel strobe in leader mode
	sequence s_ldr_load;
		!leader_sel && rx.char_stb[0];
	endsequence
	a_pins_open_drain: assert property (bond_all_o == 1'b0 && bond_status_code_o == 2'h0)
		else $error("pin driven high");
	a_follower_silent: assert property (leader_sel && $past(leader_sel) |-> bond_status_code_oe == 2'h0)
		else $error("follower drives");
	a_leader_code: assert property (s_ldr_load |=> bond_status_code_oe == ~$past(rx.ldr_code))
		else $error("leader code");
	a_flag_framed: assert property ($fell(bond_all_oe) |-> rx.framed == 4'hf or ##[0:1] s_axi_bvalid)
		else $error("flag unframed");
	a_flag_resolving: assert property ($fell(bond_all_oe) |-> $past(rx.seq_seen, 2) == 4'hf or ##[0:1] s_axi_bvalid)
		else $error("flag early");
	a_action_exclusive: assert property ((eb.ins_k285 & eb.del_frame) == 4'h0)
		else $error("insert and delete");
	a_inhibit_hold: assert property (!bond_inhibit_n && rx.seq_seen != 4'hf |=> eb.align_en == 4'h0)
		else $error("align inhibited");
	a_free_align: assert property (bond_inhibit_n |=> eb.align_en == $past(rx.seq_seen))
		else $error("align free");
endmodule
// Attach to the control block
bind mdcb_ctrl mdcb_ctrl_props u_props (.sys_clk, .rstn, .leader_sel, .bond_inhibit_n, .bond_status_code_o,
	.bond_status_code_oe, .bond_all_o, .bond_all_oe, .rx, .eb, .s_axi_bvalid);

/* dv/mdcb_peer.sv */
// Peer device: domain leader sending codes, or a member holding
// the shared flag low. Bench resolves the open-drain nets.
module mdcb_peer
	import mdcb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic lead,
	input wire logic hold_low,
	input wire mdcb_status_t code,
	output logic [1:0] code_oe,
	output logic all_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Pin pulls
	// ----
	// Pulls change one clock after the request
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			code_oe <= 2'h0;
			all_oe <= 1'b1;
		end else begin
			code_oe <= lead ? ~code : 2'h0;
			all_oe <= hold_low;
		end
	end
endmodule

/* dv/test_multi_device_channel_bonding_control.sv */
// Bench: bus, leader and follower codes, flag, inhibit.
// Assumes mdcb_peer stands for the other device.
module test_multi_device_channel_bonding_control
	import mdcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Signals and instances
	// ----
	logic sys_clk = 1'b0, rstn = 1'b0, leader_sel = 1'b0, bond_inhibit_n = 1'b0, p_lead = 1'b0, p_hold = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, s;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] c, bond_status_code_o, bond_status_code_oe, s_axi_bresp, s_axi_rresp, p_code_oe;
	logic bond_all_o, bond_all_oe, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic p_all_oe, acc_ins, acc_del;
	mdcb_status_t p_code = MDCB_ST_NORMAL;
	mdcb_rx_t rx = '0;
	mdcb_eb_t eb;
	int fail_count = 0, checks = 0;
	wire logic [1:0] bond_status_code_i = ~(bond_status_code_oe | p_code_oe);
	wire logic bond_all_i = ~(bond_all_oe | p_all_oe);
	mdcb_ctrl i_dut (.sys_clk, .rstn, .leader_sel, .bond_inhibit_n, .bond_status_code_i, .bond_status_code_o,
		.bond_status_code_oe, .bond_all_i, .bond_all_o, .bond_all_oe, .rx, .eb, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	mdcb_peer i_peer (.sys_clk, .rstn, .lead(p_lead), .hold_low(p_hold), .code(p_code), .code_oe(p_code_oe),
		.all_oe(p_all_oe));
	// Clock, action collector, watchdog
	initial forever #20 sys_clk = ~sys_clk;
	always @(negedge sys_clk) begin
		acc_ins |= |eb.ins_k285;
		acc_del |= |eb.del_frame;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		fail_count++;
		summarize();
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic [1:0] act_of(input logic [1:0] v);
		return {v == 2'h1, v == 2'h2};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic do_reset();
		rstn <= 1'b0;
		tick(8);
		rstn <= 1'b1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, d);
		chk("rresp", s_axi_rresp, r);
	endtask
	task automatic lead_code(input logic [1:0] v);
		rx.ldr_code <= v;
		rx.char_stb <= 4'h1 | 4'($urandom);
		tick(1);
		rx.char_stb <= 4'h0;
		tick(1);
	endtask
	// ----
	// Scenarios
	// ----
	initial begin
		void'($urandom(90));
		do_reset();
		rd(MDCB_REG_CTRL, MDCB_CTRL_RST, MDCB_RESP_OKAY);
		rd(4'hc, 32'h0, MDCB_RESP_SLVERR);
		for (int i = 0; i < 12; i++) begin
			c = (i < 4) ? 2'(i) : 2'($urandom);
			lead_code(c);
			chk("leader pin", bond_status_code_i, c);
		end
		leader_sel <= 1'b1;
		p_lead <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			c = (i < 4) ? 2'(i) : 2'($urandom);
			p_code <= mdcb_status_t'(c);
			tick(2);
			// First strobe latches the code, second one applies it
			rx.char_stb <= 4'($urandom) | 4'h2;
			tick(1);
			rx.char_stb <= 4'h0;
			tick(3);
			acc_ins = 1'b0;
			acc_del = 1'b0;
			rx.char_stb <= 4'($urandom) | 4'h2;
			tick(1);
			rx.char_stb <= 4'h0;
			tick(4);
			chk("follower act", {acc_ins, acc_del}, act_of(c));
			chk("follower oe", bond_status_code_oe, 2'h0);
		end
		leader_sel <= 1'b0;
		p_lead <= 1'b0;
		rx.seq_seen <= 4'($urandom) & 4'h7;
		rx.framed <= 4'hf;
		tick(6);
		chk("align held", eb.align_en, 4'h0);
		chk("flag busy", bond_all_i, 1'b0);
		rx.seq_seen <= 4'hf;
		rx.framed <= 4'h7;
		tick(6);
		chk("flag unframed", bond_all_i, 1'b0);
		chk("align all", eb.align_en, 4'hf);
		rx.framed <= 4'hf;
		tick(4);
		chk("flag bonded", bond_all_i, 1'b1);
		p_hold <= 1'b1;
		tick(2);
		chk("flag wired", bond_all_i, 1'b0);
		p_hold <= 1'b0;
		bond_inhibit_n <= 1'b1;
		rx.seq_seen <= 4'h0;
		rx.framed <= 4'h0;
		do_reset();
		s = 4'h0;
		for (int i = 0; i < 8; i++) begin
			s = s | 4'($urandom);
			rx.seq_seen <= s;
			tick(2);
			chk("free align", eb.align_en, s);
		end
		bond_inhibit_n <= 1'b0;
		rx.seq_seen <= 4'h0;
		for (int j = 0; j < 2; j++) begin
			do_reset();
			lead_code(2'h1);
			chk("active oe", bond_status_code_oe, 2'h2);
			wr(MDCB_REG_CTRL, j ? 32'hf2 : 32'hf1);
			tick(2);
			chk("idle oe", bond_status_code_oe, 2'h0);
			chk("idle flag", bond_all_oe, 1'b0);
		end
		do_reset();
		wr(MDCB_REG_CTRL, 32'he3);
		rd(MDCB_REG_CTRL, 32'he3, MDCB_RESP_OKAY);
		rx.seq_seen <= 4'hf;
		rx.framed <= 4'hf;
		tick(8);
		chk("no bond flag", bond_all_i, 1'b0);
		chk("no bond align", eb.align_en, 4'h0);
		summarize();
	end
endmodule
